// ===== hw/pts_regs.svh
// Constants of the program table sequencer
// Summary of operation
// - Each step names its successor; the end value returns to canceled; end is default.
// - A new positioning command during a move from a non-endless step flags motion conflict and halts.
// - Endless-travel step without registration lets the next step shift speed directly.
// - Any other speed change by the next step is refused with motion conflict.
// - Table writes only while canceled; otherwise refused with table-locked error.
// - Run rising while canceled captures step-select inputs as the starting step.
// - Run falling while operating enters stopped and halts the move.
// - Run rising while stopped resumes without recapturing the step-select inputs.
// - Resume from stopped is allowed while the motor still decelerates.
// - Abort rising edge while stopped with run inactive cancels; ignored elsewhere.
// - Exactly three states: canceled, operating, stopped; starts canceled.
// - Resume after error skips failed step, or runs its next repetition.
// - Response after run turns on falls within 2-6, 2-8, 2-6 ms windows.
// - Extended windows apply after error stop, stopped move, pending latch, overtravel.
// - Repeat count 1 to 99999, default 1; successor used after all repetitions.
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH
`define PTS_CLK_NS 20
`define PTS_RESP_MIN_US 2000
`define PTS_RESP_CYC ((`PTS_RESP_MIN_US * 1000 + `PTS_CLK_NS - 1) / `PTS_CLK_NS)
`define PTS_STEP_W 8
`define PTS_SUCC_W 9
`define PTS_SUCC_END 9'h100
`define PTS_REP_W 17
`define PTS_REP_DEFAULT 17'h00001
`define PTS_REP_MAX 17'h1869F
`endif

// ===== hw/pts_pkg.sv
// Types of the program table sequencer
`include "pts_regs.svh"
package pts_pkg;
  typedef enum logic [1:0] {ST_CANCELED, ST_OPERATING, ST_STOPPED} pts_state_t;
  typedef struct packed {
    logic [`PTS_SUCC_W-1:0] succ;
    logic [`PTS_REP_W-1:0] rep;
    logic endless;
    logic registration_distance_field_set;
  } pts_entry_t;
  localparam pts_entry_t PTS_ENTRY_DEFAULT = '{succ: `PTS_SUCC_END, rep: `PTS_REP_DEFAULT,
                                               endless: 1'b0, registration_distance_field_set: 1'b0};
endpackage

// ===== hw/pts_sequencer.sv
// Program table sequencer: step table, run/stop/abort state machine, error flags
`timescale 1ns/10ps
`include "pts_regs.svh"
module pts_sequencer #(
  parameter int STEPS = 256,
  parameter int RESP_CYC = `PTS_RESP_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host discrete pins, asynchronous
  input wire logic run_req,
  input wire logic program_abort_input,
  input wire logic [`PTS_STEP_W-1:0] step_select_inputs,
  // Table write port
  input wire logic tbl_wr,
  input wire logic [`PTS_STEP_W-1:0] tbl_wr_idx,
  input wire pts_pkg::pts_entry_t tbl_wr_entry,
  // Motion and event logic, same clock
  input wire logic event_go,
  input wire logic move_busy,
  input wire logic latch_pending,
  input wire logic overtravel,
  input wire logic err_clr,
  // Motion commands
  output logic move_start,
  output logic [`PTS_STEP_W-1:0] table_step_index,
  output logic move_halt,
  output logic speed_shift,
  // Status
  output pts_pkg::pts_state_t seq_state,
  output logic ext_window,
  output logic motion_conflict_error,
  output logic table_locked_error
);
  import pts_pkg::*;

  localparam int CW = $clog2(RESP_CYC + 1);
  localparam logic [CW-1:0] RESP_LAST = CW'(RESP_CYC - 1);

  typedef struct packed {
    pts_entry_t [STEPS-1:0] tbl;
    pts_state_t state;
    logic [`PTS_STEP_W-1:0] cur;
    logic [`PTS_REP_W-1:0] rep_done;
    logic err_stop;
    logic prev_stop;
    logic wait_on;
    logic [CW-1:0] wait_cnt;
    logic run_s1, run_s2, run_s3;
    logic abt_s1, abt_s2, abt_s3;
    logic [`PTS_STEP_W-1:0] sel_s1, sel_s2;
    logic move_start, move_halt, speed_shift, ext_window;
    logic conflict_err, lock_err;
  } pts_core_t;

  pts_core_t q, d;
  pts_entry_t cur_ent;
  logic run_rise, abt_rise, adv_end, speed_ok, ev_ok;
  logic [`PTS_STEP_W-1:0] adv_step;
  logic [`PTS_REP_W-1:0] adv_rep;

  // Repetition first, successor only once the count is used up
  function automatic logic [`PTS_REP_W+`PTS_STEP_W:0] pts_advance(input pts_entry_t e,
      input logic [`PTS_STEP_W-1:0] cur, input logic [`PTS_REP_W-1:0] done);
    logic [`PTS_REP_W-1:0] n;
    n = done + `PTS_REP_W'(1);
    if (n < e.rep)
      pts_advance = {1'b0, n, cur};
    else
      pts_advance = {e.succ[`PTS_SUCC_W-1], `PTS_REP_W'(0), e.succ[`PTS_STEP_W-1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cur_ent = q.tbl[q.cur];
    run_rise = q.run_s2 & ~q.run_s3;
    abt_rise = q.abt_s2 & ~q.abt_s3;
    {adv_end, adv_rep, adv_step} = pts_advance(cur_ent, q.cur, q.rep_done);
    speed_ok = cur_ent.endless & ~cur_ent.registration_distance_field_set;
    ev_ok = (q.state == ST_OPERATING) & q.run_s2 & ~q.wait_on & event_go;
    d = q;
    d.move_start = 1'b0;
    d.move_halt = 1'b0;
    d.speed_shift = 1'b0;
    // Stage one feeds stage two only
    d.run_s1 = run_req;
    d.run_s2 = q.run_s1;
    d.run_s3 = q.run_s2;
    d.abt_s1 = program_abort_input;
    d.abt_s2 = q.abt_s1;
    d.abt_s3 = q.abt_s2;
    d.sel_s1 = step_select_inputs;
    d.sel_s2 = q.sel_s1;
    // Clear first so a same-cycle set wins
    if (err_clr) begin
      d.conflict_err = 1'b0;
      d.lock_err = 1'b0;
    end
    if (tbl_wr) begin
      if (q.state == ST_CANCELED)
        d.tbl[tbl_wr_idx] = tbl_wr_entry;
      else
        d.lock_err = 1'b1;
    end
    unique case (q.state)
      ST_CANCELED: begin
        if (run_rise) begin
          d.state = ST_OPERATING;
          d.cur = q.sel_s2;
          d.rep_done = '0;
          d.err_stop = 1'b0;
          d.prev_stop = 1'b0;
          d.wait_on = 1'b1;
          d.wait_cnt = '0;
          d.ext_window = latch_pending | overtravel;
        end
      end
      ST_OPERATING: begin
        if (!q.run_s2) begin
          d.state = ST_STOPPED;
          d.move_halt = 1'b1;
          d.wait_on = 1'b0;
          d.prev_stop = 1'b1;
        end else if (q.wait_on) begin
          // Fixed least delay lands inside every window, normal or extended
          if (q.wait_cnt == RESP_LAST) begin
            d.wait_on = 1'b0;
            d.move_start = 1'b1;
          end else begin
            d.wait_cnt = q.wait_cnt + CW'(1);
          end
        end else if (event_go) begin
          if (adv_end) begin
            d.state = ST_CANCELED;
          end else if (move_busy && !speed_ok) begin
            d.conflict_err = 1'b1;
            d.err_stop = 1'b1;
            d.state = ST_STOPPED;
            d.move_halt = 1'b1;
          end else begin
            d.cur = adv_step;
            d.rep_done = adv_rep;
            d.move_start = 1'b1;
            d.speed_shift = move_busy;
          end
        end
      end
      ST_STOPPED: begin
        if (run_rise) begin
          // Deceleration is not waited for
          d.state = ST_OPERATING;
          d.wait_on = 1'b1;
          d.wait_cnt = '0;
          d.ext_window = q.err_stop | q.prev_stop | latch_pending | overtravel;
          d.err_stop = 1'b0;
          if (q.err_stop) begin
            d.cur = adv_step;
            d.rep_done = adv_rep;
            if (adv_end) begin
              d.state = ST_CANCELED;
              d.wait_on = 1'b0;
            end
          end
        end else if (abt_rise && !q.run_s2) begin
          d.state = ST_CANCELED;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.tbl <= {STEPS{PTS_ENTRY_DEFAULT}};
    end else begin
      q <= d;
    end
  end

  assign move_start = q.move_start;
  assign table_step_index = q.cur;
  assign move_halt = q.move_halt;
  assign speed_shift = q.speed_shift;
  assign seq_state = q.state;
  assign ext_window = q.ext_window;
  assign motion_conflict_error = q.conflict_err;
  assign table_locked_error = q.lock_err;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_stop_seen;
    q.state == ST_STOPPED && q.move_halt;
  endsequence

  property p_end_cancels;
    @(posedge mclk) disable iff (rst) ev_ok && adv_end |=> q.state == ST_CANCELED;
  endproperty
  a_end_cancels: assert property (p_end_cancels) else $error("end successor did not cancel");

  property p_conflict;
    @(posedge mclk) disable iff (rst) ev_ok && !adv_end && move_busy && !speed_ok
      |=> s_stop_seen and q.conflict_err;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not flagged");

  property p_speed_shift;
    @(posedge mclk) disable iff (rst) ev_ok && !adv_end && move_busy && speed_ok
      |=> q.speed_shift && q.move_start && !$rose(q.conflict_err) ##1 !q.speed_shift;
  endproperty
  a_speed_shift: assert property (p_speed_shift) else $error("speed shift refused");

  property p_reject_speed;
    @(posedge mclk) disable iff (rst) q.speed_shift |-> $past(speed_ok);
  endproperty
  a_reject_speed: assert property (p_reject_speed) else $error("speed changed on finite step");

  property p_lock;
    @(posedge mclk) disable iff (rst) tbl_wr && q.state != ST_CANCELED
      |=> q.lock_err && q.tbl == $past(q.tbl);
  endproperty
  a_lock: assert property (p_lock) else $error("locked table was written");

  property p_capture;
    @(posedge mclk) disable iff (rst) q.state == ST_CANCELED && run_rise
      |=> q.state == ST_OPERATING && q.cur == $past(q.sel_s2) && q.wait_on;
  endproperty
  a_capture: assert property (p_capture) else $error("start step not captured");

  property p_stop;
    @(posedge mclk) disable iff (rst) q.state == ST_OPERATING && !q.run_s2 |=> s_stop_seen;
  endproperty
  a_stop: assert property (p_stop) else $error("run drop did not stop");

  property p_resume;
    @(posedge mclk) disable iff (rst) q.state == ST_STOPPED && run_rise && !q.err_stop
      |=> q.state == ST_OPERATING && q.cur == $past(q.cur);
  endproperty
  a_resume: assert property (p_resume) else $error("resume recaptured or failed");

  property p_abort;
    @(posedge mclk) disable iff (rst) q.state == ST_STOPPED && abt_rise && !q.run_s2
      |=> q.state == ST_CANCELED;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored while stopped");

  property p_states;
    @(posedge mclk) disable iff (rst) q.state inside {ST_CANCELED, ST_OPERATING, ST_STOPPED};
  endproperty
  a_states: assert property (p_states) else $error("illegal sequencer state");

  property p_resp;
    @(posedge mclk) disable iff (rst) q.state == ST_OPERATING && q.run_s2 && q.wait_on
      && q.wait_cnt == RESP_LAST |=> q.move_start && !q.wait_on;
  endproperty
  a_resp: assert property (p_resp) else $error("start not issued at response delay");

  property p_start_after_wait;
    @(posedge mclk) disable iff (rst) q.move_start && !q.speed_shift && $past(q.wait_on)
      |-> $past(q.wait_cnt) == RESP_LAST;
  endproperty
  a_start_after_wait: assert property (p_start_after_wait) else $error("start issued early");
endmodule

// ===== tb/pts_host.sv
// Host controller model driving the sequence control pins
`timescale 1ns/10ps
`include "pts_regs.svh"
module pts_host (
  // Clock
  input wire logic mclk,
  // Sequence control pins
  output logic run_req,
  output logic program_abort_input,
  output logic [`PTS_STEP_W-1:0] step_select_inputs
);
  initial begin
    run_req = 1'b0;
    program_abort_input = 1'b0;
    step_select_inputs = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Run level held two cycles, abort pulse three high and three low, so the synchronisers never miss them
  task automatic run(input logic v);
    @(posedge mclk) run_req <= v;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic sel(input logic [`PTS_STEP_W-1:0] v);
    @(posedge mclk) step_select_inputs <= v;
  endtask
  task automatic abort_pulse();
    @(posedge mclk) program_abort_input <= 1'b1;
    repeat (3) @(posedge mclk);
    program_abort_input <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
endmodule

// ===== tb/pts_sequencer_tb_top.sv
// Self-checking testbench of the program table sequencer
`timescale 1ns/10ps
`include "pts_regs.svh"
module program_table_sequencer_tb_top;
  import pts_pkg::*;
  localparam int RC = 4;
  logic mclk, rst, tbl_wr, event_go, move_busy, err_clr, latch_pending, overtravel;
  logic [`PTS_STEP_W-1:0] tbl_wr_idx;
  pts_entry_t tbl_wr_entry;
  logic run_req, program_abort_input, move_start, move_halt, speed_shift, ext_window;
  logic motion_conflict_error, table_locked_error;
  logic [`PTS_STEP_W-1:0] step_select_inputs, table_step_index, r;
  pts_state_t seq_state;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  pts_host host (.mclk(mclk), .run_req(run_req), .program_abort_input(program_abort_input),
    .step_select_inputs(step_select_inputs));
  pts_sequencer #(.STEPS(256), .RESP_CYC(RC)) DUT (.mclk(mclk), .rst(rst), .run_req(run_req),
    .program_abort_input(program_abort_input), .step_select_inputs(step_select_inputs),
    .tbl_wr(tbl_wr), .tbl_wr_idx(tbl_wr_idx), .tbl_wr_entry(tbl_wr_entry), .event_go(event_go),
    .move_busy(move_busy), .latch_pending(latch_pending), .overtravel(overtravel), .err_clr(err_clr),
    .move_start(move_start), .table_step_index(table_step_index), .move_halt(move_halt),
    .speed_shift(speed_shift), .seq_state(seq_state), .ext_window(ext_window),
    .motion_conflict_error(motion_conflict_error), .table_locked_error(table_locked_error));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Each move start is matched with the oldest noted step and speed shift
  // Sampled mid-cycle, well clear of the edge that launches the pulse
  always @(negedge mclk) begin
    if (move_start === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("ERROR %0t unexpected start %h", $time, table_step_index);
      end else check({speed_shift, table_step_index}, exp_q.pop_front());
    end
  end
  task automatic wait_state(input pts_state_t s);
    for (int i = 0; i < 20 && seq_state !== s; i++) @(posedge mclk) #1;
    check(seq_state, s);
  endtask
  task automatic wait_start();
    for (int i = 0; i < 30 && move_start !== 1'b1; i++) @(posedge mclk) #1;
    check(move_start, 1'b1);
  endtask
  task automatic wr(input logic [7:0] i, input logic [8:0] s, input logic [16:0] n, input logic e);
    @(posedge mclk) tbl_wr <= 1'b1;
    tbl_wr_idx <= i;
    tbl_wr_entry <= '{succ: s, rep: n, endless: e, registration_distance_field_set: 1'b0};
    @(posedge mclk) tbl_wr <= 1'b0;
  endtask
  task automatic ev(input logic b);
    @(posedge mclk) event_go <= 1'b1;
    move_busy <= b;
    @(posedge mclk) event_go <= 1'b0;
    move_busy <= 1'b0;
    #1;
  endtask
  task automatic start_at(input logic [7:0] s);
    host.sel(s);
    host.run(1'b1);
    wait_state(ST_OPERATING);
    check(table_step_index, s);
    exp_q.push_back({1'b0, s});
    wait_start();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rst <= 1'b1;
    tbl_wr <= 1'b0;
    tbl_wr_idx <= 8'h00;
    tbl_wr_entry <= PTS_ENTRY_DEFAULT;
    event_go <= 1'b0;
    move_busy <= 1'b0;
    err_clr <= 1'b0;
    latch_pending <= 1'b0;
    overtravel <= 1'b0;
    r = 8'($urandom(35));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    #1 check(seq_state, ST_CANCELED);
    wr(8'h05, 9'h006, 17'h00002, 1'b0);
    wr(8'h06, `PTS_SUCC_END, 17'h00001, 1'b0);
    wr(8'h07, 9'h008, 17'h00001, 1'b0);
    wr(8'h09, 9'h00A, 17'h00001, 1'b1);
    // Repeat twice, then successor, then end; an accepted write would loop back
    start_at(8'h05);
    check(ext_window, 1'b0);
    wr(8'h06, 9'h005, 17'h00001, 1'b0);
    #1 check(table_locked_error, 1'b1);
    @(posedge mclk) err_clr <= 1'b1;
    @(posedge mclk) err_clr <= 1'b0;
    #1 check(table_locked_error, 1'b0);
    exp_q.push_back(9'h005);
    ev(1'b0);
    wait_start();
    exp_q.push_back(9'h006);
    ev(1'b0);
    wait_start();
    ev(1'b0);
    wait_state(ST_CANCELED);
    host.run(1'b0);
    // Endless step lets the next step shift speed while moving
    @(posedge mclk) overtravel <= 1'b1;
    start_at(8'h09);
    check(ext_window, 1'b1);
    overtravel <= 1'b0;
    exp_q.push_back(9'h10A);
    ev(1'b1);
    wait_start();
    ev(1'b0);
    wait_state(ST_CANCELED);
    host.run(1'b0);
    // Next command during a bounded move is a conflict
    start_at(8'h07);
    ev(1'b1);
    wait_state(ST_STOPPED);
    check(motion_conflict_error, 1'b1);
    host.run(1'b0);
    // Resume skips the failed step and goes on at its successor
    exp_q.push_back(9'h008);
    host.run(1'b1);
    wait_start();
    check(table_step_index, 8'h08);
    check(ext_window, 1'b1);
    host.run(1'b0);
    wait_state(ST_STOPPED);
    host.abort_pulse();
    wait_state(ST_CANCELED);
    @(posedge mclk) err_clr <= 1'b1;
    @(posedge mclk) err_clr <= 1'b0;
    // Stop and resume; upper half avoids the steps written above
    r = {1'b1, r[6:0]};
    @(posedge mclk) latch_pending <= r[0];
    start_at(r);
    check(ext_window, r[0]);
    host.abort_pulse();
    check(seq_state, ST_OPERATING);
    host.run(1'b0);
    wait_state(ST_STOPPED);
    check(move_halt, 1'b1);
    host.sel(~r);
    move_busy <= 1'b1;
    exp_q.push_back({1'b0, r});
    host.run(1'b1);
    wait_start();
    check(ext_window, 1'b1);
    host.run(1'b0);
    wait_state(ST_STOPPED);
    move_busy <= 1'b0;
    host.abort_pulse();
    wait_state(ST_CANCELED);
    check(9'(exp_q.size()), 9'h000);
    give_verdict();
  end
endmodule
